// [rtl/eotp_pkg.sv]
// Purpose: shared constants and types for the serial EEPROM OTP and read engine
// Assumes: 125 MHz system clock, bus pins sampled synchronously
// Notes: one address pointer serves the array, the protect register and the OTP bank
package eotp_pkg;
  localparam logic [3:0] CODE_ARRAY = 4'ha;
  localparam logic [3:0] CODE_SEC = 4'hb;
  localparam logic [15:0] WP_ADDR = 16'h0401;
  localparam logic [5:0] OTP_LOCK_IDX = 6'h3f;
  localparam int unsigned OTP_USER_BYTES = 64;
  localparam int unsigned WP_BPH_BIT = 3;
  localparam int unsigned WP_BPL_BIT = 2;
  localparam logic [2:0] DEV_SEL_DEF = 3'h0;
  localparam int unsigned ARR_AW_DEF = 13;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_WRITE_NS = 40000;
  localparam int unsigned WR_CYCLES_DEF = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_ACK = 3'h2,
    ST_AHOLD = 3'h3,
    ST_TX = 3'h4,
    ST_MACK = 3'h5
  } eotp_state_t;

  typedef enum logic [1:0] {
    RL_CTRL = 2'h0,
    RL_ADRH = 2'h1,
    RL_ADRL = 2'h2,
    RL_DATA = 2'h3
  } eotp_role_t;

  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } eotp_line_t;

  typedef struct packed {
    logic we;
    logic [5:0] idx;
    logic [7:0] data;
  } eotp_stage_t;
endpackage

// [rtl/eotp_line_events.sv]
// Purpose: edge and START/STOP detection on the two-wire bus
// Assumes: i_scl and i_sda already synchronous to i_clk
// Notes: events lag the pins by two clocks, all aligned
`timescale 1ns/1ps
module eotp_line_events (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output eotp_pkg::eotp_line_t o_ev
);
  import eotp_pkg::*;
  logic [1:0] scl_q, scl_d, sda_q, sda_d;
  eotp_line_t ev_q, ev_d;

  always_comb begin
    scl_d = {scl_q[0], i_scl};
    sda_d = {sda_q[0], i_sda};
    ev_d.scl_rise = scl_q[0] & ~scl_q[1];
    ev_d.scl_fall = ~scl_q[0] & scl_q[1];
    // Data moving while the clock is high marks a frame edge
    ev_d.start = scl_q[0] & scl_q[1] & sda_q[1] & ~sda_q[0];
    ev_d.stop = scl_q[0] & scl_q[1] & ~sda_q[1] & sda_q[0];
    ev_d.sda = sda_q[0];
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_q <= 2'h3;
      sda_q <= 2'h3;
      ev_q <= '0;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      ev_q <= ev_d;
    end
  end

  assign o_ev = ev_q;
endmodule

// [rtl/eotp_otp_store.sv]
// Purpose: 128-byte security bank with staging buffer and lock
// Assumes: stage and clear/commit never share a cycle
// Notes: staging indexes by final location, so buffer wrap equals address wrap
`timescale 1ns/1ps
module eotp_otp_store #(
  // Factory half contents; value is arbitrary
  parameter logic [511:0] FACTORY_ID = {64{8'h5a}}
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input eotp_pkg::eotp_stage_t i_stage,
  input wire logic i_clear,
  input wire logic i_commit,
  input wire logic [6:0] i_rd_idx,
  output logic [7:0] o_rd_data,
  output logic o_any_pend,
  output logic o_locked
);
  import eotp_pkg::*;
  logic [7:0] user_mem [OTP_USER_BYTES];
  logic [7:0] stage_mem [OTP_USER_BYTES];
  logic [63:0] pend_q, pend_d;
  logic lock_q, lock_d;

  always_comb begin
    pend_d = pend_q;
    lock_d = lock_q;
    if (i_clear || i_commit) begin
      pend_d = '0;
    end
    if (i_commit && !lock_q && pend_q[OTP_LOCK_IDX]) begin
      lock_d = 1'b1;
    end
    if (i_stage.we) begin
      pend_d[i_stage.idx] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pend_q <= '0;
      lock_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      lock_q <= lock_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_stage.we) begin
      stage_mem[i_stage.idx] <= i_stage.data;
    end
  end

  // Only the user half has a write path at all
  for (genvar i = 0; i < OTP_USER_BYTES; i++) begin : g_user
    always_ff @(posedge i_clk) begin
      if (i_commit && pend_q[i] && !lock_q) begin
        user_mem[i] <= stage_mem[i];
      end
    end
  end

  always_comb begin
    if (i_rd_idx[6]) begin
      o_rd_data = FACTORY_ID[{i_rd_idx[5:0], 3'h0} +: 8];
    end else begin
      o_rd_data = user_mem[i_rd_idx[5:0]];
    end
  end

  assign o_any_pend = |pend_q;
  assign o_locked = lock_q;
endmodule

// [rtl/eotp_core.sv]
// Purpose: two-wire slave engine for polling, security writes and reads
// Assumes: SCL high and low phases each last several i_clk periods
// Notes: array write data and protect register writes are handled elsewhere
`timescale 1ns/1ps
module eotp_core #(
  parameter int unsigned WR_CYCLES = eotp_pkg::WR_CYCLES_DEF,
  parameter int unsigned ARR_AW = eotp_pkg::ARR_AW_DEF,
  parameter logic [2:0] DEV_SEL = eotp_pkg::DEV_SEL_DEF,
  // Factory half contents; value is arbitrary
  parameter logic [511:0] FACTORY_ID = {64{8'h5a}}
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic [ARR_AW-1:0] o_arr_addr,
  input wire logic [7:0] i_arr_data,
  input wire logic i_arr_busy,
  input wire logic i_block_protect_high,
  input wire logic i_block_protect_low,
  output logic o_write_busy,
  output logic o_otp_locked
);
  import eotp_pkg::*;

  localparam int unsigned BW = $clog2(WR_CYCLES + 1);
  localparam logic [15:0] ARR_MASK = 16'((32'h1 << ARR_AW) - 32'h1);

  // ************************************************
  // State
  // ************************************************
  eotp_line_t ev;
  eotp_stage_t stage;
  eotp_state_t st_q, st_d;
  eotp_role_t role_q, role_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ahi_q, ahi_d;
  logic [15:0] ptr_q, ptr_d;
  logic [BW-1:0] busy_q, busy_d;
  logic rw_q, rw_d, sec_q, sec_d, ack_q, ack_d, oe_q, oe_d;
  logic otp_ok_q, otp_ok_d, rd_pend_q, rd_pend_d, mack_q, mack_d;
  logic wbusy_q, wbusy_d;
  logic commit, clear, any_pend, busy;
  logic [7:0] rx_byte, rd_byte, otp_byte, wp_byte;

  // ************************************************
  // Pointer step
  // ************************************************
  // Array reads roll over at the top; bank reads count through
  function automatic logic [15:0] next_ptr(input logic sec, input logic [15:0] p);
    logic [15:0] n;
    n = 16'(p + 16'h1);
    if (!sec) begin
      n = n & ARR_MASK;
    end
    return n;
  endfunction

  // ************************************************
  // Submodules
  // ************************************************
  eotp_line_events u_line (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_ev(ev)
  );

  eotp_otp_store #(
    .FACTORY_ID(FACTORY_ID)
  ) u_store (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_stage(stage),
    .i_clear(clear),
    .i_commit(commit),
    .i_rd_idx(ptr_q[6:0]),
    .o_rd_data(otp_byte),
    .o_any_pend(any_pend),
    .o_locked(o_otp_locked)
  );

  // ************************************************
  // Read data source
  // ************************************************
  always_comb begin
    wp_byte = 8'h00;
    wp_byte[WP_BPH_BIT] = i_block_protect_high;
    wp_byte[WP_BPL_BIT] = i_block_protect_low;
    if (!sec_q) begin
      rd_byte = i_arr_data;
    end else if (ptr_q == WP_ADDR) begin
      rd_byte = wp_byte;
      // Unmapped bank addresses read as fill, never as unknown
    end else if (ptr_q[15:7] == 9'h000) begin
      rd_byte = otp_byte;
    end else begin
      rd_byte = FILL_BYTE;
    end
  end

  // ************************************************
  // Bus sequencer
  // ************************************************
  always_comb begin
    st_d = st_q;
    role_d = role_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ahi_d = ahi_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    sec_d = sec_q;
    ack_d = ack_q;
    oe_d = oe_q;
    otp_ok_d = otp_ok_q;
    rd_pend_d = rd_pend_q;
    mack_d = mack_q;
    busy_d = busy_q;
    stage = '0;
    commit = 1'b0;
    clear = 1'b0;
    rx_byte = {sh_q[6:0], ev.sda};
    busy = (busy_q != '0) || i_arr_busy;
    if (busy_q != '0) begin
      busy_d = BW'(busy_q - 1'b1);
    end
    wbusy_d = (busy_d != '0) || i_arr_busy;
    if (ev.start || ev.stop) begin
      oe_d = 1'b0;
      mack_d = 1'b0;
      if (rd_pend_q) begin
        ptr_d = next_ptr(sec_q, ptr_q);
        rd_pend_d = 1'b0;
      end
      if (ev.stop && otp_ok_q && any_pend) begin
        // Locked commits still run the timer, so polling looks the same
        commit = 1'b1;
        busy_d = BW'(WR_CYCLES);
        wbusy_d = 1'b1;
      end else begin
        clear = 1'b1;
      end
      otp_ok_d = 1'b0;
      cnt_d = 3'h0;
      role_d = RL_CTRL;
      st_d = ev.start ? ST_RX : ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          oe_d = 1'b0;
        end
        ST_RX: begin
          if (ev.scl_rise) begin
            sh_d = rx_byte;
            cnt_d = 3'(cnt_q + 3'h1);
            if (cnt_q == 3'h7) begin
              st_d = ST_ACK;
              ack_d = 1'b1;
              unique case (role_q)
                RL_CTRL: begin
                  rw_d = rx_byte[0];
                  sec_d = (rx_byte[7:4] == CODE_SEC);
                  if ((rx_byte[7:4] != CODE_SEC && rx_byte[7:4] != CODE_ARRAY) ||
                      rx_byte[3:1] != DEV_SEL || busy) begin
                    ack_d = 1'b0;
                  end
                end
                RL_ADRH: begin
                  ahi_d = rx_byte;
                end
                RL_ADRL: begin
                  ptr_d = {ahi_q, rx_byte};
                  otp_ok_d = sec_q && ahi_q == 8'h00 && rx_byte[7:6] == 2'h0;
                end
                RL_DATA: begin
                  if (otp_ok_q) begin
                    stage.we = 1'b1;
                    stage.idx = ptr_q[5:0];
                    stage.data = rx_byte;
                    ptr_d = {ptr_q[15:6], 6'(ptr_q[5:0] + 6'h1)};
                  end
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (ev.scl_fall) begin
            if (ack_q) begin
              oe_d = 1'b1;
              st_d = ST_AHOLD;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_AHOLD: begin
          if (ev.scl_fall) begin
            oe_d = 1'b0;
            cnt_d = 3'h0;
            st_d = ST_RX;
            unique case (role_q)
              RL_CTRL: begin
                role_d = RL_ADRH;
                if (rw_q) begin
                  sh_d = rd_byte;
                  oe_d = ~rd_byte[7];
                  rd_pend_d = 1'b1;
                  role_d = RL_DATA;
                  st_d = ST_TX;
                end
              end
              RL_ADRH: role_d = RL_ADRL;
              default: role_d = RL_DATA;
            endcase
          end
        end
        ST_TX: begin
          if (ev.scl_fall) begin
            if (cnt_q == 3'h7) begin
              oe_d = 1'b0;
              st_d = ST_MACK;
            end else begin
              cnt_d = 3'(cnt_q + 3'h1);
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        ST_MACK: begin
          if (ev.scl_rise) begin
            if (!ev.sda) begin
              ptr_d = next_ptr(sec_q, ptr_q);
              rd_pend_d = 1'b0;
              mack_d = 1'b1;
            end else begin
              st_d = ST_IDLE;
            end
          end else if (ev.scl_fall && mack_q) begin
            mack_d = 1'b0;
            sh_d = rd_byte;
            oe_d = ~rd_byte[7];
            rd_pend_d = 1'b1;
            cnt_d = 3'h0;
            st_d = ST_TX;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q <= ST_IDLE;
      role_q <= RL_CTRL;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      ahi_q <= 8'h00;
      ptr_q <= 16'h0000;
      rw_q <= 1'b0;
      sec_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      otp_ok_q <= 1'b0;
      rd_pend_q <= 1'b0;
      mack_q <= 1'b0;
      busy_q <= '0;
      wbusy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      role_q <= role_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ahi_q <= ahi_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      sec_q <= sec_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      otp_ok_q <= otp_ok_d;
      rd_pend_q <= rd_pend_d;
      mack_q <= mack_d;
      busy_q <= busy_d;
      wbusy_q <= wbusy_d;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  // Open drain: the data level is always low, only the enable moves
  assign o_sda_o = 1'b0;
  assign o_sda_oe = oe_q;
  assign o_arr_addr = ptr_q[ARR_AW-1:0];
  assign o_write_busy = wbusy_q;
endmodule

// [bench/eotp_core_props.sv]
// Purpose: port-level properties of the serial memory engine
// Assumes: one clock, synchronous active-high reset
// Notes: write timer length is judged only while the array side is idle
`timescale 1ns/1ps
module eotp_core_props #(
  parameter int unsigned WR_CYCLES = 5000,
  parameter int unsigned ARR_AW = 13
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic [ARR_AW-1:0] o_arr_addr,
  input wire logic [7:0] i_arr_data,
  input wire logic i_arr_busy,
  input wire logic i_block_protect_high,
  input wire logic i_block_protect_low,
  input wire logic o_write_busy,
  input wire logic o_otp_locked
);
  logic [15:0] bcnt_q, bcnt_d;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ****************
  // Busy span counter
  // ****************
  always_comb begin
    bcnt_d = o_write_busy ? bcnt_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge i_clk) begin
    bcnt_q <= i_sys_rst ? 16'h0 : bcnt_d;
  end
  AST_RST_CLEAR: assert property (disable iff (1'b0)
    i_sys_rst |=> !o_sda_oe && !o_otp_locked && o_arr_addr == '0)
    else $error("state not cleared by reset");
  AST_NOACK_BUSY: assert property (
    o_write_busy && $past(o_write_busy, 8) |-> !o_sda_oe)
    else $error("data line pulled during write cycle");
  AST_BUSY_LEN: assert property (
    $fell(o_write_busy) && !$past(i_arr_busy, 2) |-> bcnt_q == 16'(WR_CYCLES))
    else $error("write cycle length wrong");
  AST_ARR_BUSY: assert property (i_arr_busy |=> o_write_busy)
    else $error("array busy not reflected");
  AST_LOCK_HOLD: assert property (o_otp_locked |=> o_otp_locked)
    else $error("lock dropped");
  AST_LOCK_COMMIT: assert property ($rose(o_otp_locked) |-> ##[0:1] o_write_busy)
    else $error("lock without write cycle");
  AST_OE_AT_LOW: assert property (
    $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
    else $error("data line changed outside clock low");
  AST_WRITE_AT_STOP: assert property (
    $rose(o_write_busy) && !$past(i_arr_busy) |-> $past(i_scl, 3) && $past(i_sda, 3) &&
    !$past(i_sda, 4))
    else $error("write cycle started without a stop");
  CVR_BUSY: cover property ($rose(o_write_busy));
  CVR_LOCK: cover property ($rose(o_otp_locked));
  CVR_ACK: cover property ($rose(o_sda_oe) && !i_arr_busy);
endmodule
bind eotp_core eotp_core_props #(.WR_CYCLES(WR_CYCLES), .ARR_AW(ARR_AW)) u_eotp_core_props (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_arr_addr(o_arr_addr), .i_arr_data(i_arr_data),
  .i_arr_busy(i_arr_busy), .i_block_protect_high(i_block_protect_high),
  .i_block_protect_low(i_block_protect_low), .o_write_busy(o_write_busy),
  .o_otp_locked(o_otp_locked));

// [bench/eotp_mst.sv]
// Purpose: behavioural two-wire bus master
// Assumes: bench resolves the wire with a pull-up
// Notes: clock stands high between frames; data released when idle
`timescale 1ns/1ps
module eotp_mst (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Also a repeated START when entered with the clock low
  task automatic start();
    wt(2);
    o_sda <= 1'b1;
    wt(6);
    o_scl <= 1'b1;
    wt(8);
    o_sda <= 1'b0;
    wt(8);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    wt(2);
    o_sda <= 1'b0;
    wt(6);
    o_scl <= 1'b1;
    wt(8);
    o_sda <= 1'b1;
    wt(8);
  endtask
  // Data moves two cycles after the clock falls, never together with it
  task automatic xbit(input logic b, output logic s);
    wt(2);
    o_sda <= b;
    wt(6);
    o_scl <= 1'b1;
    wt(8);
    s = i_line;
    o_scl <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(b[i], s);
    xbit(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 0; i < 8; i++) begin
      xbit(1'b1, s);
      b = {b[6:0], s};
    end
    xbit(!mack, s);
  endtask
endmodule

// [bench/tb_eotp_core.sv]
// Purpose: self-checking bench of the serial memory engine
// Assumes: short write timer, open-drain wire with pull-up
// Notes: user bytes are read only after being written once
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_eotp_core;
  import eotp_pkg::*;
  localparam int unsigned WRC = 400;
  // Factory pattern, distinct per byte lane; value is arbitrary
  localparam logic [511:0] FID = {8{64'h7f6e5d4c3b2a1908}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic abusy = 1'b0;
  logic bph = 1'b0;
  logic bpl = 1'b0;
  logic [7:0] adata = 8'h00;
  logic scl, msda, sdao, oe, busy, locked;
  logic [12:0] addr;
  logic [7:0] got [4];
  wire logic sda_line = msda & (oe ? sdao : 1'b1);
  int fail_count = 0;
  int tests_run = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) adata <= addr[7:0] ^ 8'h3c;
  eotp_core #(.WR_CYCLES(WRC), .FACTORY_ID(FID)) u_eotp_core (.i_clk(clk), .i_sys_rst(rst),
    .i_scl(scl),
    .i_sda(sda_line), .o_sda_o(sdao), .o_sda_oe(oe), .o_arr_addr(addr), .i_arr_data(adata),
    .i_arr_busy(abusy), .i_block_protect_high(bph), .i_block_protect_low(bpl),
    .o_write_busy(busy), .o_otp_locked(locked));
  eotp_mst u_eotp_mst (.i_clk(clk), .i_line(sda_line), .o_scl(scl), .o_sda(msda));
  // ****************
  // Bus helpers
  // ****************
  task automatic wb(input logic [7:0] b, input logic ea);
    logic a;
    u_eotp_mst.wbyte(b, a);
    `CHK("ack", ea, a)
  endtask
  task automatic setp(input logic [3:0] c, input logic [15:0] a);
    u_eotp_mst.start();
    wb({c, DEV_SEL_DEF, 1'b0}, 1'b1);
    wb(a[15:8], 1'b1);
    wb(a[7:0], 1'b1);
  endtask
  task automatic rd(input logic [3:0] c, input int n);
    u_eotp_mst.start();
    wb({c, DEV_SEL_DEF, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) u_eotp_mst.rbyte(i < n - 1, got[i]);
    u_eotp_mst.stop();
  endtask
  task automatic wsec(input logic [15:0] a, input int n, input logic [7:0] d);
    setp(CODE_SEC, a);
    for (int i = 0; i < n; i++) wb(d + 8'(i), 1'b1);
    u_eotp_mst.stop();
  endtask
  task automatic poll(output int k);
    logic a;
    k = 0;
    do begin
      u_eotp_mst.start();
      u_eotp_mst.wbyte({CODE_SEC, DEV_SEL_DEF, 1'b0}, a);
      k++;
    end while (!a && k < 20);
    u_eotp_mst.stop();
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_poll();
    int k;
    wsec(16'h0005, 2, 8'ha1);
    poll(k);
    `CHK("polls", 1'b1, k > 1 && k < 20)
    `CHK("unlocked", 1'b0, locked)
    setp(CODE_SEC, 16'h0005);
    rd(CODE_SEC, 2);
    `CHK("sec5", 8'ha1, got[0])
    `CHK("sec6", 8'ha2, got[1])
    abusy <= 1'b1;
    u_eotp_mst.start();
    wb({CODE_ARRAY, DEV_SEL_DEF, 1'b0}, 1'b0);
    u_eotp_mst.stop();
    abusy <= 1'b0;
    $display("t_poll done");
  endtask
  task automatic t_abort_gate();
    logic a;
    logic [15:0] bad [2] = '{16'h0040, 16'h0080};
    setp(CODE_SEC, 16'h0009);
    wb(8'h77, 1'b1);
    u_eotp_mst.start();
    u_eotp_mst.stop();
    repeat (4) @(posedge clk);
    `CHK("abort", 1'b0, busy)
    for (int i = 0; i < 2; i++) begin
      setp(CODE_SEC, bad[i]);
      u_eotp_mst.wbyte(8'h11, a);
      u_eotp_mst.stop();
      repeat (4) @(posedge clk);
      `CHK("gate", 1'b0, busy)
    end
    setp(CODE_SEC, 16'h0040);
    rd(CODE_SEC, 2);
    `CHK("factory", FID[7:0], got[0])
    `CHK("factory1", FID[15:8], got[1])
    u_eotp_mst.start();
    wb({CODE_SEC, ~DEV_SEL_DEF, 1'b0}, 1'b0);
    u_eotp_mst.start();
    wb({4'h6, DEV_SEL_DEF, 1'b0}, 1'b0);
    u_eotp_mst.stop();
    $display("t_abort_gate done");
  endtask
  task automatic t_wp();
    for (int i = 0; i < 4; i++) begin
      {bph, bpl} <= 2'(i);
      setp(CODE_SEC, WP_ADDR);
      rd(CODE_SEC, 1);
      `CHK("wp", {4'h0, 2'(i), 2'b00}, got[0])
    end
    rd(CODE_SEC, 1);
    `CHK("wp_next", FILL_BYTE, got[0])
    $display("t_wp done");
  endtask
  task automatic t_lock_roll();
    int k;
    wsec(16'h003e, 3, 8'hc0);
    poll(k);
    `CHK("locked", 1'b1, locked)
    setp(CODE_SEC, 16'h003e);
    rd(CODE_SEC, 3);
    `CHK("b3e", 8'hc0, got[0])
    `CHK("b3f", 8'hc1, got[1])
    `CHK("b40", FID[7:0], got[2])
    wsec(16'h0005, 1, 8'h33);
    poll(k);
    setp(CODE_SEC, 16'h0005);
    rd(CODE_SEC, 1);
    `CHK("kept", 8'ha1, got[0])
    setp(CODE_ARRAY, 16'h1fff);
    rd(CODE_ARRAY, 1);
    `CHK("top", 8'hc3, got[0])
    rd(CODE_SEC, 1);
    `CHK("roll", 8'hc2, got[0])
    $display("t_lock_roll done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_poll();
    t_abort_gate();
    t_wp();
    t_lock_roll();
    print_verdict();
  end
  // Roughly four times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
